// ===== rtl/pp_regs.sv
// Single-pair PMA ability and control registers behind an AXI4-Lite slave
//
// Operation
// - Decode registers only in device address one
// - Presence field of status two reads 10
// - Status two bit 9 reads one
// - Status two bit 8 reads one
// - Status two bit 0 reads one
// - Transmit-off bit one suppresses line transmitter
// - Extended abilities bit 11 reads one
// - Single-pair ability register ignores all writes
// - Ability bit 2 always reads one
// - Ability bit 3 always reads zero
// - Ability bit 1 always reads zero
// - Ability bit 0 always reads zero
// - Leader-select one makes leader, zero follower
// - Leader-select ignored while autonegotiation enabled
// - Type selector resets to 0010, four codes
// - Type selector applies only when forced, no autonegotiation
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pp_regs
  import pp_regs_pkg::*;
(
  input wire logic aclk, // 125 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [DATA_W/8-1:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [DATA_W-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic leader_strap, // Role strap pin, asynchronous
  input wire logic an_enable, // Autonegotiation enabled
  input wire logic forced_config, // Forced link configuration mode
  input wire logic an_leader, // Negotiated role, 1 = leader
  input wire logic [3:0] an_phy_type, // Negotiated PHY type code
  output pp_link_cfg_t link_cfg // Role, type and transmit-off
);

  pp_ctrl_t ctrl;
  logic transmit_off;
  logic strap_pending;
  logic [2:0] strap_sync;
  logic [2:0] strap_fill;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W/8-1:0] w_strb;
  logic do_write;
  pp_sel_t wr_sel;
  pp_sel_t rd_sel;
  logic [REG_W-1:0] rd_word;

  function automatic pp_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[IDX_LSB +: 16];
    decode = SEL_NONE;
    if (addr[DEV_LSB +: DEV_W] == PMA_DEVICE) begin
      case (idx)
        IDX_SECOND_STATUS: decode = SEL_STATUS2;
        IDX_TRANSMIT_DISABLE: decode = SEL_TXDIS;
        IDX_EXTENDED_ABILITIES: decode = SEL_EXTABL;
        IDX_SINGLE_PAIR_ABILITY: decode = SEL_SPABL;
        IDX_SINGLE_PAIR_CONTROL: decode = SEL_SPCTRL;
        default: decode = SEL_NONE;
      endcase
    end
  endfunction : decode

  // Write channel: address and data taken independently, then combined
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel = decode(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Strap synchroniser; only stages two and three are compared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_sync <= 3'h0;
    end else begin
      strap_sync <= {strap_sync[1:0], leader_strap};
    end
  end

  // Stages hold reset zeros at first; agreement counts only once filled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_fill <= 3'h0;
    end else begin
      strap_fill <= {strap_fill[1:0], 1'b1};
    end
  end

  // Transmit-off; read-only words have no write path at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_off <= RST_TRANSMIT_DISABLE[TRANSMIT_OFF_BIT];
    end else if (do_write && wr_sel == SEL_TXDIS && w_strb[0]) begin
      transmit_off <= w_data[TRANSMIT_OFF_BIT];
    end
  end

  // Leader select waits for a settled strap after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_pending <= 1'b1;
      ctrl.leader_select <= RST_SINGLE_PAIR_CONTROL[LEADER_BIT];
    end else if (do_write && wr_sel == SEL_SPCTRL && w_strb[1]) begin
      strap_pending <= 1'b0;
      ctrl.leader_select <= w_data[LEADER_BIT];
    end else if (strap_pending && strap_fill[2]
                 && strap_sync[1] == strap_sync[2]) begin
      strap_pending <= 1'b0;
      ctrl.leader_select <= strap_sync[2];
    end
  end

  // Reserved codes are stored as written; software keeps to long reach
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl.phy_type_selector <= RST_SINGLE_PAIR_CONTROL[TYPE_MSB:TYPE_LSB];
    end else if (do_write && wr_sel == SEL_SPCTRL && w_strb[0]) begin
      ctrl.phy_type_selector <= w_data[TYPE_MSB:TYPE_LSB];
    end
  end

  // Read channel: one request in flight, data registered
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel = decode(s_axi_araddr);

  always_comb begin
    rd_word = '0;
    case (rd_sel)
      SEL_STATUS2: begin
        rd_word[PRESENCE_MSB:PRESENCE_LSB] = PRESENCE_VALUE;
        rd_word[EXT_ABLE_BIT] = 1'b1;
        rd_word[TX_OFF_ABLE_BIT] = 1'b1;
        rd_word[LOOPBACK_ABLE_BIT] = 1'b1;
      end
      SEL_TXDIS: begin
        rd_word[TRANSMIT_OFF_BIT] = transmit_off;
      end
      SEL_EXTABL: begin
        rd_word[SINGLE_PAIR_ABLE_BIT] = 1'b1;
      end
      SEL_SPABL: begin
        rd_word[LONG_REACH_BIT] = 1'b1;
        rd_word[SHORT_REACH_BIT] = 1'b0;
        rd_word[GIGABIT_BIT] = 1'b0;
        rd_word[FAST_BIT] = 1'b0;
      end
      SEL_SPCTRL: begin
        rd_word = RST_SINGLE_PAIR_CONTROL;
        rd_word[LEADER_BIT] = ctrl.leader_select;
        rd_word[TYPE_MSB:TYPE_LSB] = ctrl.phy_type_selector;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {{(DATA_W-REG_W){1'b0}}, rd_word};
      s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Link configuration, registered so outputs come from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_cfg.link_leader <= 1'b0;
      link_cfg.phy_type <= TYPE_LONG_REACH;
      link_cfg.transmit_off <= 1'b0;
    end else begin
      link_cfg.link_leader <= an_enable ? an_leader
                                        : ctrl.leader_select;
      link_cfg.phy_type <= (!an_enable && forced_config)
                           ? ctrl.phy_type_selector
                           : an_phy_type;
      link_cfg.transmit_off <= transmit_off;
    end
  end

endmodule : pp_regs
`default_nettype wire

// ===== rtl/pp_regs_pkg.sv
// Package: map, field layout and reset values of the single-pair PMA group
package pp_regs_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // Byte address = {device[4:0], register index[15:0], 2'b00}
  localparam int DEV_LSB = 18;
  localparam int DEV_W = 5;
  localparam int IDX_LSB = 2;
  localparam logic [DEV_W-1:0] PMA_DEVICE = 5'h01;
  localparam logic [15:0] IDX_SECOND_STATUS = 16'h0008;
  localparam logic [15:0] IDX_TRANSMIT_DISABLE = 16'h0009;
  localparam logic [15:0] IDX_EXTENDED_ABILITIES = 16'h000B;
  localparam logic [15:0] IDX_SINGLE_PAIR_ABILITY = 16'h0012;
  localparam logic [15:0] IDX_SINGLE_PAIR_CONTROL = 16'h0834;
  localparam logic [15:0] RST_SECOND_STATUS = 16'h8301;
  localparam logic [15:0] RST_TRANSMIT_DISABLE = 16'h0000;
  localparam logic [15:0] RST_EXTENDED_ABILITIES = 16'h0800;
  localparam logic [15:0] RST_SINGLE_PAIR_ABILITY = 16'h0004;
  localparam logic [15:0] RST_SINGLE_PAIR_CONTROL = 16'h8002;
  // Second status, transmit-disable and ability word fields
  localparam int PRESENCE_MSB = 15;
  localparam int PRESENCE_LSB = 14;
  localparam logic [1:0] PRESENCE_VALUE = 2'h2;
  localparam int EXT_ABLE_BIT = 9;
  localparam int TX_OFF_ABLE_BIT = 8;
  localparam int LOOPBACK_ABLE_BIT = 0;
  localparam int TRANSMIT_OFF_BIT = 0;
  localparam int SINGLE_PAIR_ABLE_BIT = 11;
  localparam int SHORT_REACH_BIT = 3;
  localparam int LONG_REACH_BIT = 2;
  localparam int GIGABIT_BIT = 1;
  localparam int FAST_BIT = 0;
  // Single-pair control word fields
  localparam int CTRL_RSVD_BIT = 15;
  localparam int LEADER_BIT = 14;
  localparam int TYPE_MSB = 3;
  localparam int TYPE_LSB = 0;
  localparam logic [3:0] TYPE_FAST = 4'h0;
  localparam logic [3:0] TYPE_GIGABIT = 4'h1;
  localparam logic [3:0] TYPE_LONG_REACH = 4'h2;
  localparam logic [3:0] TYPE_SHORT_REACH = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_STATUS2, SEL_TXDIS, SEL_EXTABL, SEL_SPABL, SEL_SPCTRL
  } pp_sel_t;

  // Writable state of the control word
  typedef struct packed {
    logic leader_select;
    logic [3:0] phy_type_selector;
  } pp_ctrl_t;

  // Configuration that the link logic acts on
  typedef struct packed {
    logic link_leader;
    logic [3:0] phy_type;
    logic transmit_off;
  } pp_link_cfg_t;
endpackage : pp_regs_pkg

// ===== verification/pp_regs_properties.sv
// Checker: bus answers and link configuration of the register group
`timescale 1ns/1ps
`default_nettype none
module pp_regs_properties
  import pp_regs_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // AW addr
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // W data
  input wire logic [DATA_W/8-1:0] s_axi_wstrb, // W strobes
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic [ADDR_W-1:0] s_axi_araddr, // AR addr
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [DATA_W-1:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic an_enable, // AN on
  input wire logic forced_config, // Forced
  input wire logic an_leader, // AN role
  input wire logic [3:0] an_phy_type, // AN type
  input wire pp_link_cfg_t link_cfg // Link cfg
);
  logic wt;
  logic rt;
  assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rt = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_status_read: assert property (
    rt && s_axi_araddr == 23'h40020 |=> s_axi_rdata == 32'h8301)
    else $error("status word wrong");
  a_ext_read: assert property (
    rt && s_axi_araddr == 23'h4002C |=> s_axi_rdata == 32'h800)
    else $error("extended word wrong");
  a_ability_read: assert property (
    rt && s_axi_araddr == 23'h40048 |=> s_axi_rdata == 32'h4)
    else $error("ability word wrong");
  a_foreign_read: assert property (
    rt && s_axi_araddr[22:18] != PMA_DEVICE |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("foreign read answered");
  a_foreign_write: assert property (
    wt && s_axi_awaddr[22:18] != PMA_DEVICE |-> ##2
    s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("foreign write accepted");
  a_txoff_apply: assert property (
    wt && s_axi_awaddr == 23'h40024 && s_axi_wstrb[0] |-> ##3
    link_cfg.transmit_off == $past(s_axi_wdata[0], 3))
    else $error("transmit off not applied");
  a_leader_apply: assert property (
    wt && s_axi_awaddr == 23'h420D0 && s_axi_wstrb[1] |-> ##3
    ($past(an_enable) || link_cfg.link_leader == $past(s_axi_wdata[14], 3)))
    else $error("leader select not applied");
  a_role_neg: assert property (
    $past(aresetn) && $past(an_enable) |->
    link_cfg.link_leader == $past(an_leader))
    else $error("negotiated role ignored");
  a_type_neg: assert property (
    $past(aresetn) && $past(an_enable || !forced_config) |->
    link_cfg.phy_type == $past(an_phy_type))
    else $error("negotiated type ignored");
  c_write: cover property (wt);
  c_read: cover property (rt);
  c_neg: cover property (an_enable && an_leader);
endmodule : pp_regs_properties
bind pp_regs pp_regs_properties i_props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .an_enable, .forced_config,
  .an_leader, .an_phy_type, .link_cfg);
`default_nettype wire

// ===== verification/pp_regs_tb.sv
// Testbench: register access and link configuration
`timescale 1ns/1ps
`default_nettype none
module pp_regs_tb
  import pp_regs_pkg::*;
;
  localparam logic [22:0] A_ST = 23'h40020, A_TX = 23'h40024;
  localparam logic [22:0] A_EX = 23'h4002C, A_AB = 23'h40048, A_CT = 23'h420D0;
  logic aclk = 0, aresetn = 0, leader_strap = 1;
  logic [22:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0, an_phy_type = 4'h3;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, an_enable = 0, an_leader = 0;
  logic forced_config = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  pp_link_cfg_t link_cfg;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'h2};
  int mismatches = 0, cmp_count = 0;
  pp_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .leader_strap, .an_enable,
    .forced_config, .an_leader, .an_phy_type, .link_cfg);
  initial forever #4 aclk = ~aclk;
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Handshakes sampled at negedge: same values the next rising edge takes
  task automatic wr(input logic [22:0] a, logic [31:0] d, logic [3:0] s,
    logic [1:0] er);
    int n;
    logic at, wt, dn;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    dn = 0;
    for (n = 0; n < 40 && !dn; n++) begin
      @(negedge aclk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      dn = s_axi_bvalid;
      if (dn) chk("bresp", er, s_axi_bresp);
      @(posedge aclk);
      if (at) s_axi_awvalid <= 0;
      if (wt) s_axi_wvalid <= 0;
      if (dn) s_axi_bready <= 0;
    end
    if (!dn) begin
      chk("write_timeout", 1, 0);
      results();
    end
  endtask : wr
  task automatic rd(input logic [22:0] a, logic [31:0] e, logic [1:0] er);
    int n;
    logic hs, dn;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    dn = 0;
    for (n = 0; n < 40 && !dn; n++) begin
      @(negedge aclk);
      hs = s_axi_arvalid && s_axi_arready;
      dn = s_axi_rvalid;
      if (dn) chk("rdata", e, s_axi_rdata);
      if (dn) chk("rresp", er, s_axi_rresp);
      @(posedge aclk);
      if (hs) s_axi_arvalid <= 0;
      if (dn) s_axi_rready <= 0;
    end
    if (!dn) begin
      chk("read_timeout", 1, 0);
      results();
    end
  endtask : rd
  task automatic lk(input logic [5:0] e);
    repeat (2) @(negedge aclk);
    chk("link_cfg", e, link_cfg);
  endtask : lk
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (6) @(posedge aclk);
    rd(A_ST, 32'h8301, RESP_OKAY);
    rd(A_TX, 32'h0, RESP_OKAY);
    rd(A_EX, 32'h800, RESP_OKAY);
    rd(A_AB, 32'h4, RESP_OKAY);
    rd(A_CT, 32'hC002, RESP_OKAY);
    lk(6'h24);
    wr(A_AB, 32'hFFFF, 4'hF, RESP_OKAY);
    rd(A_AB, 32'h4, RESP_OKAY);
    wr(A_ST, 32'h0, 4'hF, RESP_OKAY);
    rd(A_ST, 32'h8301, RESP_OKAY);
    wr(A_TX, 32'hFFFF, 4'hF, RESP_OKAY);
    rd(A_TX, 32'h1, RESP_OKAY);
    lk(6'h25);
    wr(A_TX, 32'h0, 4'hE, RESP_OKAY);
    rd(A_TX, 32'h1, RESP_OKAY);
    wr(A_TX, 32'h0, 4'h1, RESP_OKAY);
    lk(6'h24);
    // Last code is the long-reach one, the only setting software keeps
    foreach (codes[k]) begin
      wr(A_CT, {28'h0, codes[k]}, 4'h3, RESP_OKAY);
      rd(A_CT, {28'h800, codes[k]}, RESP_OKAY);
      lk({1'b0, codes[k], 1'b0});
    end
    wr(A_CT, 32'h4002, 4'h3, RESP_OKAY);
    wr(A_CT, 32'h0002, 4'h1, RESP_OKAY);
    rd(A_CT, 32'hC002, RESP_OKAY);
    lk(6'h24);
    @(posedge aclk);
    an_enable <= 1;
    lk(6'h06);
    @(posedge aclk);
    an_leader <= 1;
    lk(6'h26);
    @(posedge aclk);
    {an_enable, forced_config, an_phy_type} <= 6'h0;
    lk(6'h20);
    rd(23'h80020, 32'h0, RESP_SLVERR);
    wr(23'h00024, 32'h1, 4'hF, RESP_SLVERR);
    rd(A_TX, 32'h0, RESP_OKAY);
    rd(23'h40004, 32'h0, RESP_SLVERR);
    results();
  end
endmodule : pp_regs_tb
`default_nettype wire
